/* File: design/ddr2_cmd_burst.sv */
// ddr2 device command decode, bank state, burst engine and small array
`timescale 1ns/100ps
module ddr2_cmd_burst #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 4,
  parameter int COL_W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ddr2_cmd_pkg::cmd_pins_type pins,
  input wire logic [DQ_W-1:0] wrData,
  input wire logic dm,
  output logic [DQ_W-1:0] rdData,
  output logic rdValid,
  output logic [ddr2_cmd_pkg::BANKS-1:0] bankOpen,
  output logic selfRefresh,
  output logic dllOn,
  output logic [ddr2_cmd_pkg::MODE_W-1:0] modeSettings,
  output logic [ddr2_cmd_pkg::ADDR_W-1:0] refreshRow
);
  localparam int CNT_W = $clog2(ddr2_cmd_pkg::ROW_CLOSE_CYC + 1);
  localparam int TICK_W = $clog2(ddr2_cmd_pkg::SELF_TICK_CYC + 1);
  localparam int MEM_W = ddr2_cmd_pkg::BA_W + ROW_W + COL_W;

  if (COL_W < 3 || COL_W > ddr2_cmd_pkg::COL_MAX || ROW_W < 1 ||
      ROW_W > ddr2_cmd_pkg::ADDR_W || DQ_W < 1) begin : g_bad_size
    $error("ddr2_cmd_burst: unsupported row, column or data width");
  end

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [ddr2_cmd_pkg::MODE_W-1:0] mode;
    logic [2:0] posted;
    ddr2_cmd_pkg::access_type [ddr2_cmd_pkg::MAX_POSTED-1:0] pipe;
    ddr2_cmd_pkg::engine_type eng;
    logic bWr;
    logic bAp;
    logic bLen8;
    logic bOrder;
    logic [ddr2_cmd_pkg::BA_W-1:0] bBank;
    logic [ROW_W-1:0] bRow;
    logic [COL_W-1:0] bCol;
    logic [2:0] beat;
    logic [2:0] waitCnt;
    logic [ddr2_cmd_pkg::BANKS-1:0] open;
    logic [ddr2_cmd_pkg::BANKS-1:0][ROW_W-1:0] row;
    logic [ddr2_cmd_pkg::BANKS-1:0][CNT_W-1:0] closeCnt;
    logic recOn;
    logic [3:0] recCnt;
    logic [ddr2_cmd_pkg::BA_W-1:0] recBank;
    logic [DQ_W-1:0] rdData;
    logic rdValid;
    logic selfRef;
    logic dllOn;
    logic [ddr2_cmd_pkg::ADDR_W-1:0] refRow;
    logic [TICK_W-1:0] tick;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [DQ_W-1:0] mem [2**MEM_W];
  logic memWe;
  logic [MEM_W-1:0] memAddr;
  logic [DQ_W-1:0] memData;

  // low three column bits of a beat
  function automatic logic [2:0] beatLow(input logic [2:0] start, input logic [2:0] idx,
                                         input logic order);
    logic [1:0] nib;
    nib = start[1:0] + idx[1:0];
    if (order) begin
      return start ^ idx;
    end
    return {start[2] ^ idx[2], nib};
  endfunction

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    ddr2_cmd_pkg::cmd_type cmd;
    ddr2_cmd_pkg::access_type acc;
    ddr2_cmd_pkg::access_type issued;
    logic [2:0] rdLat;
    logic [3:0] wrRec;
    logic [COL_W-1:0] col;
    logic allIdle;
    logic [2:0] lastBeat;
    cmd = ddr2_cmd_pkg::CMD_NOP;
    acc = '0;
    issued = '0;
    col = '0;
    memWe = 1'b0;
    memAddr = '0;
    memData = wrData;
    s_d = s_q;
    s_d.rdValid = 1'b0;
    s_d.mode[ddr2_cmd_pkg::LOOPRST_BIT] = 1'b0;

    rdLat = s_q.mode[ddr2_cmd_pkg::RDLAT_LSB +: 3];
    if (rdLat < ddr2_cmd_pkg::RDLAT_MIN) begin
      rdLat = ddr2_cmd_pkg::RDLAT_MIN;
    end
    wrRec = {1'b0, s_q.mode[ddr2_cmd_pkg::WREC_LSB +: 3]} + 4'h1;
    if (wrRec == 4'h1) begin
      wrRec = 4'h2;
    end
    lastBeat = s_q.bLen8 ? 3'h7 : 3'h3;

    // deselect and nop both leave cmd at nop; bursts below keep running
    if (!s_q.selfRef && !pins.csN) begin
      unique case ({pins.rasN, pins.casN, pins.weN})
        3'b000: cmd = pins.cke ? ddr2_cmd_pkg::CMD_LOAD : ddr2_cmd_pkg::CMD_NOP;
        3'b011: cmd = pins.cke ? ddr2_cmd_pkg::CMD_OPEN : ddr2_cmd_pkg::CMD_NOP;
        3'b101: cmd = pins.cke ? ddr2_cmd_pkg::CMD_READ : ddr2_cmd_pkg::CMD_NOP;
        3'b100: cmd = pins.cke ? ddr2_cmd_pkg::CMD_WRITE : ddr2_cmd_pkg::CMD_NOP;
        3'b010: cmd = pins.cke ? ddr2_cmd_pkg::CMD_CLOSE : ddr2_cmd_pkg::CMD_NOP;
        3'b001: cmd = pins.cke ? ddr2_cmd_pkg::CMD_REFRESH : ddr2_cmd_pkg::CMD_SELF;
        default: cmd = ddr2_cmd_pkg::CMD_NOP;
      endcase
    end

    for (int b = 0; b < ddr2_cmd_pkg::BANKS; b++) begin
      if (s_q.closeCnt[b] != '0) begin
        s_d.closeCnt[b] = s_q.closeCnt[b] - CNT_W'(1);
      end
    end
    // loads, refreshes and self refresh are dropped unless nothing is busy
    allIdle = (s_q.open == '0) && (s_q.eng == ddr2_cmd_pkg::ENG_IDLE) && !s_q.recOn;
    for (int b = 0; b < ddr2_cmd_pkg::BANKS; b++) begin
      if (s_q.closeCnt[b] != '0) begin
        allIdle = 1'b0;
      end
    end

    // write recovery before the internal close of a write with auto close
    if (s_q.recOn) begin
      if (s_q.recCnt <= 4'h1) begin
        s_d.recOn = 1'b0;
        s_d.open[s_q.recBank] = 1'b0;
        s_d.closeCnt[s_q.recBank] = CNT_W'(ddr2_cmd_pkg::ROW_CLOSE_CYC);
      end else begin
        s_d.recCnt = s_q.recCnt - 4'h1;
      end
    end

    // ************************************************
    // burst engine
    // ************************************************
    unique case (s_q.eng)
      ddr2_cmd_pkg::ENG_IDLE: begin
      end
      ddr2_cmd_pkg::ENG_WAIT: begin
        if (s_q.waitCnt <= 3'h1) begin
          s_d.eng = ddr2_cmd_pkg::ENG_BEAT;
        end else begin
          s_d.waitCnt = s_q.waitCnt - 3'h1;
        end
      end
      ddr2_cmd_pkg::ENG_BEAT: begin
        col = s_q.bCol;
        col[2:0] = beatLow(s_q.bCol[2:0], s_q.beat, s_q.bOrder);
        if (!s_q.bLen8) begin
          col[2] = s_q.bCol[2];
        end
        memAddr = {s_q.bBank, s_q.bRow, col};
        if (s_q.bWr) begin
          memWe = !dm;
        end else begin
          s_d.rdData = mem[memAddr];
          s_d.rdValid = 1'b1;
        end
        s_d.beat = s_q.beat + 3'h1;
        if (s_q.beat == lastBeat) begin
          s_d.eng = ddr2_cmd_pkg::ENG_IDLE;
          if (s_q.bAp && s_q.bWr) begin
            s_d.recOn = 1'b1;
            s_d.recCnt = wrRec;
            s_d.recBank = s_q.bBank;
          end else if (s_q.bAp) begin
            s_d.open[s_q.bBank] = 1'b0;
            s_d.closeCnt[s_q.bBank] = CNT_W'(ddr2_cmd_pkg::ROW_CLOSE_CYC);
          end
        end
      end
      default: s_d.eng = ddr2_cmd_pkg::ENG_IDLE;
    endcase

    // ************************************************
    // posted access delay line
    // ************************************************
    if (cmd == ddr2_cmd_pkg::CMD_READ || cmd == ddr2_cmd_pkg::CMD_WRITE) begin
      acc.valid = 1'b1;
      acc.wr = (cmd == ddr2_cmd_pkg::CMD_WRITE);
      acc.ap = pins.addr[ddr2_cmd_pkg::AUTO_CLOSE_BIT];
      acc.bank = pins.ba;
      acc.col = ddr2_cmd_pkg::COL_MAX'(pins.addr[COL_W-1:0]);
    end
    // the line always shifts, so a new posted delay also retimes commands already in the line
    s_d.pipe = {s_q.pipe[ddr2_cmd_pkg::MAX_POSTED-2:0], acc};
    issued = (s_q.posted == 3'h0) ? acc : s_q.pipe[s_q.posted - 3'h1];

    // a closed bank drops the access rather than touching a stale row
    if (issued.valid && s_q.open[issued.bank]) begin
      s_d.eng = ddr2_cmd_pkg::ENG_WAIT;
      s_d.bWr = issued.wr;
      s_d.bAp = issued.ap;
      s_d.bBank = issued.bank;
      s_d.bRow = s_q.row[issued.bank];
      s_d.bCol = issued.col[COL_W-1:0];
      s_d.bLen8 = (s_q.mode[ddr2_cmd_pkg::BL_LSB +: 3] == ddr2_cmd_pkg::BL8_CODE);
      s_d.bOrder = s_q.mode[ddr2_cmd_pkg::ORDER_BIT];
      s_d.beat = 3'h0;
      s_d.waitCnt = issued.wr ? rdLat - 3'h2 : rdLat - 3'h1;
    end

    // ************************************************
    // external commands
    // ************************************************
    unique case (cmd)
      ddr2_cmd_pkg::CMD_LOAD: begin
        if (allIdle && pins.ba[1:0] == ddr2_cmd_pkg::MODE_SEL) begin
          s_d.mode = {pins.ba, pins.addr};
        end else if (allIdle && pins.ba[1:0] == ddr2_cmd_pkg::EXT_SEL) begin
          s_d.posted = pins.addr[ddr2_cmd_pkg::POSTED_LSB +: 3];
          if (s_d.posted > ddr2_cmd_pkg::POSTED_TOP) begin
            s_d.posted = ddr2_cmd_pkg::POSTED_TOP;
          end
        end
      end
      ddr2_cmd_pkg::CMD_OPEN: begin
        if (!s_q.open[pins.ba] && s_q.closeCnt[pins.ba] == '0) begin
          s_d.open[pins.ba] = 1'b1;
          s_d.row[pins.ba] = pins.addr[ROW_W-1:0];
        end
      end
      ddr2_cmd_pkg::CMD_CLOSE: begin
        for (int b = 0; b < ddr2_cmd_pkg::BANKS; b++) begin
          if (pins.addr[ddr2_cmd_pkg::AUTO_CLOSE_BIT] || pins.ba == b[ddr2_cmd_pkg::BA_W-1:0]) begin
            s_d.open[b] = 1'b0;
            s_d.closeCnt[b] = CNT_W'(ddr2_cmd_pkg::ROW_CLOSE_CYC);
          end
        end
      end
      ddr2_cmd_pkg::CMD_REFRESH: begin
        if (allIdle) begin
          s_d.refRow = s_q.refRow + 1'b1;
        end
      end
      ddr2_cmd_pkg::CMD_SELF: begin
        if (allIdle) begin
          s_d.selfRef = 1'b1;
          s_d.dllOn = 1'b0;
          s_d.tick = '0;
        end
      end
      default: begin
      end
    endcase

    // in self refresh the row counter runs from a local divider tick
    if (s_q.selfRef) begin
      if (s_q.tick == TICK_W'(ddr2_cmd_pkg::SELF_TICK_CYC - 1)) begin
        s_d.tick = '0;
        s_d.refRow = s_q.refRow + 1'b1;
      end else begin
        s_d.tick = s_q.tick + TICK_W'(1);
      end
      if (pins.cke) begin
        s_d.selfRef = 1'b0;
        s_d.dllOn = 1'b1;
      end
    end
  end

  // constants only on reset; the loop starts enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.mode <= ddr2_cmd_pkg::MODE_RESET;
      s_q.dllOn <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // array has no reset; contents are undefined until written
  // a masked beat only drops the strobe, the address still advances
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memAddr] <= memData;
    end
  end

  assign rdData = s_q.rdData;
  assign rdValid = s_q.rdValid;
  assign bankOpen = s_q.open;
  assign selfRefresh = s_q.selfRef;
  assign dllOn = s_q.dllOn;
  assign modeSettings = s_q.mode;
  assign refreshRow = s_q.refRow;
endmodule

/* File: design/ddr2_cmd_pkg.sv */
// shared constants and carrier types for the ddr2 command and burst logic
// Operation
// - nop registers nothing, work continues
// - bank lines pick mode register; banks idle
// - activate opens row until bank precharged
// - read bursts from open row, start column
// - address line ten selects auto close
// - write bursts into open row, start column
// - posted delay postpones internal access registration
// - masked write beats leave location unwritten
// - precharge closes one or all banks
// - other banks usable during auto close
// - closed bank must be activated before access
// - repeat precharge restarts close period
// - refresh uses internal row, ignores address
// - refresh with clock enable low: self refresh
// - loop off in self refresh, on after
// - mode settings hold; loop reset bit self-clears
// - beat count field sets four or eight
// - burst wraps inside aligned beat block
// - beat order bit: sequential or interleaved
// - deselect executes nothing new
// - read delay field sets three to seven
// - write auto close waits write recovery
package ddr2_cmd_pkg;
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int BANKS = 8;
  localparam int MODE_W = 17;
  localparam int MAX_POSTED = 6;
  localparam int COL_MAX = 10;
  localparam int CLK_PS = 4000;
  localparam int ROW_CLOSE_PS = 12500;
  localparam int ROW_CLOSE_CYC = (ROW_CLOSE_PS + CLK_PS - 1) / CLK_PS;
  localparam int SELF_TICK_NS = 7800;
  localparam int SELF_TICK_CYC = (SELF_TICK_NS * 1000) / CLK_PS;
  localparam int BL_LSB = 0;
  localparam int ORDER_BIT = 3;
  localparam int RDLAT_LSB = 4;
  localparam int LOOPRST_BIT = 8;
  localparam int WREC_LSB = 9;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int POSTED_LSB = 3;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] RDLAT_MIN = 3'h3;
  localparam logic [2:0] POSTED_TOP = 3'h6;
  localparam logic [1:0] MODE_SEL = 2'h0;
  localparam logic [1:0] EXT_SEL = 2'h1;
  localparam logic [MODE_W-1:0] MODE_RESET = 17'h00032;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_LOAD, CMD_OPEN, CMD_READ, CMD_WRITE, CMD_CLOSE, CMD_REFRESH, CMD_SELF
  } cmd_type;

  typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_BEAT} engine_type;

  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_type;

  typedef struct packed {
    logic valid;
    logic wr;
    logic ap;
    logic [BA_W-1:0] bank;
    logic [COL_MAX-1:0] col;
  } access_type;
endpackage

/* File: sim/ddr2_cmd_burst_sva.sv */
// assertions on the ports of the ddr2 command and burst logic
`timescale 1ns/100ps
module ddr2_cmd_burst_sva #(
  parameter int DQ_W = 8,
  parameter int ROW_W = 4,
  parameter int COL_W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ddr2_cmd_pkg::cmd_pins_type pins,
  input wire logic [DQ_W-1:0] wrData,
  input wire logic dm,
  input wire logic [DQ_W-1:0] rdData,
  input wire logic rdValid,
  input wire logic [ddr2_cmd_pkg::BANKS-1:0] bankOpen,
  input wire logic selfRefresh,
  input wire logic dllOn,
  input wire logic [ddr2_cmd_pkg::MODE_W-1:0] modeSettings,
  input wire logic [ddr2_cmd_pkg::ADDR_W-1:0] refreshRow
);
  logic live;
  logic [2:0] code;
  logic [3:0] quietCnt;
  assign live = pins.cke & ~pins.csN & ~selfRefresh;
  assign code = {pins.rasN, pins.casN, pins.weN};
  // idle time since last open bank or read beat; loads and refreshes are only judged at 8 or more
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quietCnt <= 4'h0;
    end else if ((|bankOpen) || rdValid) begin
      quietCnt <= 4'h0;
    end else if (quietCnt != 4'hf) begin
      quietCnt <= quietCnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_open_cause;
    |(bankOpen & ~$past(bankOpen)) |-> $past(live && code == 3'h3);
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("bank opened without activate");
  property p_mode_load;
    live && code == 3'h0 && pins.ba[1:0] == 2'h0 && quietCnt >= 4'h8
      |=> modeSettings == $past({pins.ba, pins.addr});
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode settings not loaded");
  property p_loop_clear;
    modeSettings[ddr2_cmd_pkg::LOOPRST_BIT] |=> !modeSettings[ddr2_cmd_pkg::LOOPRST_BIT];
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("loop reset bit stuck");
  property p_mode_hold;
    $changed(modeSettings) |-> $past(live && code == 3'h0) || $fell(modeSettings[8]);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode settings changed alone");
  property p_refresh;
    live && code == 3'h1 && quietCnt >= 4'h8 |=> refreshRow == $past(refreshRow) + 14'h0001;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh row not advanced");
  property p_self_in;
    !pins.csN && !pins.cke && code == 3'h1 && !selfRefresh && quietCnt >= 4'h8
      |=> selfRefresh && !dllOn;
  endproperty
  a_self_in: assert property (p_self_in) else $error("self refresh not entered");
  property p_self_out;
    selfRefresh && pins.cke |=> !selfRefresh && dllOn;
  endproperty
  a_self_out: assert property (p_self_out) else $error("self refresh not left");
  property p_self_hold;
    selfRefresh && !pins.cke |=> selfRefresh && !dllOn;
  endproperty
  a_self_hold: assert property (p_self_hold) else $error("self refresh dropped");
  property p_beats8;
    $rose(rdValid) && modeSettings[2:0] == ddr2_cmd_pkg::BL8_CODE |-> rdValid[*8];
  endproperty
  a_beats8: assert property (p_beats8) else $error("short burst of eight");
  property p_beats4;
    $rose(rdValid) && modeSettings[2:0] != ddr2_cmd_pkg::BL8_CODE |-> rdValid[*4] ##1 !rdValid;
  endproperty
  a_beats4: assert property (p_beats4) else $error("burst of four wrong length");
endmodule

bind ddr2_cmd_burst ddr2_cmd_burst_sva #(.DQ_W(DQ_W), .ROW_W(ROW_W), .COL_W(COL_W)) chk_u (
  .clk(clk), .rstn(rstn), .pins(pins), .wrData(wrData), .dm(dm), .rdData(rdData),
  .rdValid(rdValid), .bankOpen(bankOpen), .selfRefresh(selfRefresh), .dllOn(dllOn),
  .modeSettings(modeSettings), .refreshRow(refreshRow));

/* File: sim/ddr2_ctl_model.sv */
// controller model driving commands and write beats
`timescale 1ns/100ps
module ddr2_ctl_model #(
  parameter int DQ_W = 8,
  parameter int MODE_SET_CYC = 2
) (
  input wire logic clk,
  output ddr2_cmd_pkg::cmd_pins_type pins,
  output logic [DQ_W-1:0] wrData,
  output logic dm
);
  initial begin
    pins = {1'b1, 1'b1, 3'h7, 3'h0, 14'h0000};
    wrData = {DQ_W{1'b0}};
    dm = 1'b1;
  end
  // ****************************************
  // commands: one edge, then deselect with inverted lines
  // ****************************************
  // callers open before access, close before another row, send whole mode words
  task automatic issue(input logic [2:0] code, input logic [2:0] ba, input logic [13:0] addr,
                       input logic cke);
    @(posedge clk);
    pins <= {cke, 1'b0, code, ba, addr};
    @(posedge clk);
    pins <= {cke, 1'b1, ~code, ~ba, ~addr};
    if (code == 3'h0) begin
      repeat (MODE_SET_CYC) @(posedge clk);
    end
    if (code == 3'h2 || code == 3'h1) begin
      repeat (ddr2_cmd_pkg::ROW_CLOSE_CYC + 4) @(posedge clk);
    end
    #1;
  endtask
  task automatic hold(input logic cke, input int n);
    repeat (n) begin
      @(posedge clk);
      pins.cke <= cke;
    end
  endtask
  // released data lines show the inverse so a late sample cannot match
  task automatic beats(input logic [8*DQ_W-1:0] d, input logic [7:0] m, input int n,
                       input int lead);
    repeat (lead) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wrData <= d[i*DQ_W +: DQ_W];
      dm <= m[i];
    end
    @(posedge clk);
    wrData <= ~wrData;
    dm <= 1'b1;
  endtask
endmodule

/* File: sim/ddr2_cmd_burst_bench.sv */
// testbench for the ddr2 command and burst logic
`timescale 1ns/100ps
module ddr2_cmd_burst_bench;
  logic clk;
  logic rstn;
  ddr2_cmd_pkg::cmd_pins_type pins;
  logic [7:0] wrData;
  logic dm;
  logic [7:0] rdData;
  logic rdValid;
  logic [7:0] bankOpen;
  logic selfRefresh;
  logic dllOn;
  logic [16:0] modeSettings;
  logic [13:0] refreshRow;
  int mismatches;
  int n_tests;
  int lat;
  logic [7:0] mem [16];
  ddr2_cmd_burst dut_u (.clk(clk), .rstn(rstn), .pins(pins), .wrData(wrData), .dm(dm),
    .rdData(rdData), .rdValid(rdValid), .bankOpen(bankOpen), .selfRefresh(selfRefresh),
    .dllOn(dllOn), .modeSettings(modeSettings), .refreshRow(refreshRow));
  ddr2_ctl_model ctl_u (.clk(clk), .pins(pins), .wrData(wrData), .dm(dm));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [3:0] colOf(input logic [3:0] s, input int i, input logic il);
    logic [2:0] b;
    b = i[2:0];
    if (il) return {s[3], s[2:0] ^ b};
    return {s[3], s[2] ^ b[2], s[1:0] + b[1:0]};
  endfunction
  // ****************************************
  // bursts on bank 1; mem mirrors its open row
  // ****************************************
  task automatic wr(input logic [3:0] col, input logic [63:0] d, input logic [7:0] m,
                    input int n, input logic il);
    ctl_u.issue(3'h4, 3'h1, {3'h0, 1'b0, 6'h00, col}, 1'b1);
    ctl_u.beats(d, m, n, lat - 3);
    for (int i = 0; i < n; i++) if (!m[i]) mem[colOf(col, i, il)] = d[i*8 +: 8];
  endtask
  task automatic rd(input logic [3:0] col, input logic ap, input int n, input logic il);
    int k;
    ctl_u.issue(3'h5, 3'h1, {3'h0, ap, 6'h00, col}, 1'b1);
    k = 0;
    while (k < 40 && rdValid !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 40) begin
      mismatches++;
      stop_test();
    end
    check("read latency", lat, k);
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        @(posedge clk);
        #1;
      end
      check("read valid", 1, rdValid);
      check("read beat", mem[colOf(col, i, il)], rdData);
    end
    @(posedge clk);
    #1;
    check("burst end", 0, rdValid);
    if (ap) check("auto close", 0, bankOpen[1]);
  endtask
  task automatic s_mode();
    check("reset mode", ddr2_cmd_pkg::MODE_RESET, modeSettings);
    check("reset loop", 1, dllOn);
    ctl_u.issue(3'h0, 3'h0, 14'h0332, 1'b1);
    check("mode settings", 17'h00232, modeSettings);
    ctl_u.issue(3'h0, 3'h2, 14'h0000, 1'b1);
    check("reserved select", 17'h00232, modeSettings);
  endtask
  task automatic s_access();
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    check("bank open", 8'h02, bankOpen);
    wr(4'h4, 64'ha3a2a1a0, 8'h00, 4, 1'b0);
    rd(4'h5, 1'b0, 4, 1'b0);
    wr(4'h4, 64'hb3b2b1b0, 8'h04, 4, 1'b0);
    rd(4'h4, 1'b0, 4, 1'b0);
    ctl_u.issue(3'h7, 3'h1, 14'h0000, 1'b1);
    ctl_u.hold(1'b1, 5);
    #1;
    check("bank kept", 8'h02, bankOpen);
  endtask
  task automatic s_posted();
    ctl_u.issue(3'h2, 3'h0, 14'h0400, 1'b1);
    check("all closed", 8'h00, bankOpen);
    ctl_u.issue(3'h0, 3'h1, 14'h0008, 1'b1);
    lat = 4;
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    wr(4'h6, 64'hd1d0, 8'h00, 2, 1'b0);
    rd(4'h4, 1'b1, 4, 1'b0);
    ctl_u.hold(1'b1, 8);
    ctl_u.issue(3'h0, 3'h1, 14'h0000, 1'b1);
    lat = 3;
  endtask
  task automatic s_bl8();
    ctl_u.hold(1'b1, 8);
    ctl_u.issue(3'h0, 3'h0, 14'h023b, 1'b1);
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    wr(4'h8, 64'hc7c6c5c4c3c2c1c0, 8'h00, 8, 1'b1);
    rd(4'hb, 1'b0, 8, 1'b1);
    ctl_u.issue(3'h2, 3'h1, 14'h0000, 1'b1);
    ctl_u.issue(3'h2, 3'h1, 14'h0000, 1'b1);
    ctl_u.issue(3'h0, 3'h0, 14'h0233, 1'b1);
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    rd(4'hd, 1'b1, 8, 1'b0);
  endtask
  task automatic s_refresh();
    ctl_u.hold(1'b1, 10);
    ctl_u.issue(3'h1, 3'h0, 14'h3fff, 1'b1);
    check("refresh row", 14'h0001, refreshRow);
    ctl_u.issue(3'h1, 3'h0, 14'h0000, 1'b0);
    check("self refresh", 1, selfRefresh);
    check("loop off", 0, dllOn);
    ctl_u.hold(1'b1, 2);
    #1;
    check("self exit", 0, selfRefresh);
    check("loop on", 1, dllOn);
    ctl_u.hold(1'b1, 4);
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    rd(4'h8, 1'b1, 8, 1'b0);
  endtask
  // read delay four and a write with auto close under write recovery three
  task automatic s_recovery();
    ctl_u.hold(1'b1, 8);
    ctl_u.issue(3'h0, 3'h0, 14'h0442, 1'b1);
    lat = 4;
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    ctl_u.issue(3'h4, 3'h1, 14'h0400, 1'b1);
    ctl_u.beats(64'h93929190, 8'h00, 4, lat - 3);
    for (int i = 0; i < 4; i++) mem[i] = 8'h90 + i[7:0];
    repeat (2) @(posedge clk);
    #1;
    check("write recovery", 8'h02, bankOpen);
    @(posedge clk);
    #1;
    check("write auto close", 8'h00, bankOpen);
    ctl_u.hold(1'b1, 4);
    ctl_u.issue(3'h3, 3'h1, 14'h0002, 1'b1);
    rd(4'h0, 1'b0, 4, 1'b0);
    lat = 3;
  endtask
  initial begin
    rstn = 1'b0;
    mismatches = 0;
    n_tests = 0;
    lat = 3;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    s_mode();
    s_access();
    s_posted();
    s_bl8();
    s_refresh();
    s_recovery();
    stop_test();
  end
endmodule
